// ---- hdl/dac_if_defines.vh ----
// Register map, field positions, reset values and codes of the audio input stage.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef DAC_IF_DEFINES_VH
`define DAC_IF_DEFINES_VH
`define ADDR_INTERFACE_CONTROL 7'h03
`define ADDR_DAC_CONTROL       7'h09
`define ADDR_PAIR4_CONTROL     7'h0f
`define RST_INTERFACE_CONTROL  9'h000
`define RST_DAC_CONTROL        9'h000
`define RST_PAIR4_CONTROL      9'h000
`define FMT_HI                 1
`define FMT_LO                 0
`define LRP_BIT                2
`define BCP_BIT                3
`define IWL_HI                 5
`define IWL_LO                 4
`define PHASE_HI               8
`define PHASE_LO               6
`define DZC_BIT                0
`define OUTPUT_INVERT_PAIR4_BIT             3
`define FMT_RJ                 2'b00
`define FMT_LJ                 2'b01
`define FMT_I2S                2'b10
`define FMT_DSP                2'b11
`define IWL_16                 2'b00
`define IWL_20                 2'b01
`define IWL_24                 2'b10
`define IWL_32                 2'b11
`define AUTO16_HALF            7'd16
`define DECAY_SHIFT            6
`define VOL_RESET              8'hff
`define CTRL_WORD_BITS         16
`endif

// ---- hdl/sample_store.v ----
// Eight-entry word store for received samples, registered read data.
// Assumes one writer and one reader on the same clock; clock enable freezes it.
`timescale 1ns/1ns
`default_nettype none
module sample_store #(
    parameter DW = 24,
    parameter AW = 3
) (
    input  wire          clk,
    input  wire          arst_n,
    input  wire          ce,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Storage array, no reset needed
    always @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data always from a flip-flop
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= {DW{1'b0}};
        end else if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // sample_store
`default_nettype wire

// ---- hdl/ctrl_serial_port.v ----
// Three-wire control port: shifts address and data, latches on the latch pin.
// Assumes pins asynchronous to clk and much slower than it.
`timescale 1ns/1ns
`default_nettype none
`include "dac_if_defines.vh"
module ctrl_serial_port (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       ce,
    input  wire       ctl_clk_pin,
    input  wire       ctl_data_pin,
    input  wire       ctl_latch_pin,
    output reg  [6:0] wr_addr,
    output reg  [8:0] wr_data,
    output reg        wr_stb
);
    reg  [2:0]                   mc_s_r;
    reg  [2:0]                   ml_s_r;
    reg  [1:0]                   md_s_r;
    reg  [`CTRL_WORD_BITS-1:0]   shift_r;
    wire                         mc_rise = mc_s_r[1] & ~mc_s_r[2];
    wire                         ml_rise = ml_s_r[1] & ~ml_s_r[2];

    // Sync, shift on control clock rise, latch on latch rise
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mc_s_r  <= 3'h0;
            ml_s_r  <= 3'h0;
            md_s_r  <= 2'h0;
            shift_r <= 16'h0000;
            wr_addr <= 7'h00;
            wr_data <= 9'h000;
            wr_stb  <= 1'b0;
        end else if (ce) begin
            mc_s_r <= {mc_s_r[1:0], ctl_clk_pin};
            ml_s_r <= {ml_s_r[1:0], ctl_latch_pin};
            md_s_r <= {md_s_r[0], ctl_data_pin};
            wr_stb <= 1'b0;
            if (mc_rise) begin
                shift_r <= {shift_r[`CTRL_WORD_BITS-2:0], md_s_r[1]};
            end
            if (ml_rise) begin
                wr_addr <= shift_r[15:9];
                wr_data <= shift_r[8:0];
                wr_stb  <= 1'b1;
            end
        end
    end
endmodule // ctrl_serial_port
`default_nettype wire

// ---- hdl/dac_audio_input_format_control.v ----
// Serial audio input stage: framing, word length, phase, volume gating, soft mute.
// Assumes pins asynchronous to clk, clk much faster than the bit clock;
// mute requests and volume writes come from neighbouring logic on clk.
//
// Behaviour
// - Format field bits 1:0: 00 RJ, 01 LJ, 10 I2S, 11 DSP; resets 00.
// - Frame polarity bit 2 swaps expected frame level for left and right.
// - Swapping channels by frame inversion shifts pairing by one sample.
// - In DSP framing the frame polarity bit picks variant A (0) or B (1).
// - Sample on bit clock rise by default; bit 3 set moves to fall.
// - Word length bits 5:4: 16, 20, 24, 32 bits; resets 00.
// - 32-bit length with right-justified framing behaves as 24-bit.
// - Samples are signed, 24-bit to filters; short words zero-padded below.
// - Outside right-justified framing, 32-bit words drop their eight least significant bits.
// - 24-bit I2S accepts shorter words given 24-clock halves.
// - In 24-bit I2S a 16-high/16-low frame is detected automatically as 16-bit data.
// - Phase bits invert both channels of a pair; all reset clear.
// - With gating on, new volume waits for a zero crossing.
// - Zero-cross bit 0 low enables gating, high disables; resets 0.
// - Soft mute decays output toward mid-rail, time constant 64 samples.
// - Mute release resumes immediately from current sample, no ramp.
// - Analogue mute only in software mode and only with its enable bit.
// - Software mutes act only while control mode pin is low.
// - Control word: 7 address then 9 data bits, latched on latch rise.
// - I2S MSB on second sampling edge after frame edge; LJ on first.
// - DSP B MSB on first edge after frame rise; A on second.
// - DSP carries eight back-to-back words on line 1, pair 1 L first.
`timescale 1ns/1ns
`default_nettype none
`include "dac_if_defines.vh"
module dac_audio_input_format_control #(
    parameter SHW = 64
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        ce,
    input  wire        bit_clock,
    input  wire        frame_clock,
    input  wire [3:0]  serial_data_inputs,
    input  wire        control_clock_pin,
    input  wire        control_data_pin,
    input  wire        control_latch_pin,
    input  wire        control_mode_pin,
    input  wire        zero_detect_analog_mute,
    input  wire [3:0]  soft_mute_req,
    input  wire [7:0]  vol_value,
    input  wire [2:0]  vol_chan,
    input  wire        vol_load,
    output reg  [23:0] dac_sample,
    output reg  [2:0]  dac_channel,
    output reg         dac_valid,
    output reg  [3:0]  analog_mute,
    output reg         auto16_active
);
    localparam [1:0] P_IDLE = 2'd0;
    localparam [1:0] P_READ = 2'd1;
    localparam [1:0] P_CALC = 2'd2;
    localparam [6:0] SH_TOP = SHW;

    //************************************************************
    // Declarations
    //************************************************************
    reg  [5:0]      pin_s1_r;
    reg  [5:0]      pin_s2_r;
    reg             bclk_s3_r;
    reg  [1:0]      mode_s_r;
    reg  [8:0]      iface_r;
    reg  [8:0]      dacctl_r;
    reg  [8:0]      p4_r;
    reg             lr_prev_r;
    reg  [6:0]      cnt_r;
    reg  [6:0]      prev_half_r;
    reg             dsp_act_r;
    reg  [2:0]      slot_r;
    reg  [3:0]      pend_r;
    reg             proc_req_r;
    reg  [23:0]     hold_w_r [0:3];
    reg  [2:0]      hold_a_r [0:3];
    reg  [1:0]      st_r;
    reg  [2:0]      idx_r;
    reg  [7:0]      sign_r;
    reg  [7:0]      vpend_r;
    reg  [7:0]      vol_r [0:7];
    reg  [7:0]      vpv_r [0:7];
    reg  [23:0]     lvl_r [0:7];
    reg  [6:0]      wl_bits;
    reg  [1:0]      wsel;
    wire [95:0]     line_word;
    wire [23:0]     rd_data;
    wire [6:0]      wr_addr;
    wire [8:0]      wr_data;
    wire            wr_stb;
    integer         k;
    integer         j;
    integer         m;

    //************************************************************
    // Pin synchronisers and register fields
    //************************************************************
    // Two stages on all pins; bit clock gets a third for edge finding
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_r  <= 6'h00;
            pin_s2_r  <= 6'h00;
            bclk_s3_r <= 1'b0;
            mode_s_r  <= 2'h0;
        end else if (ce) begin
            pin_s1_r  <= {bit_clock, frame_clock, serial_data_inputs};
            pin_s2_r  <= pin_s1_r;
            bclk_s3_r <= pin_s2_r[5];
            mode_s_r  <= {mode_s_r[0], control_mode_pin};
        end
    end

    wire       sw_mode  = ~mode_s_r[1];
    wire       lr_now   = pin_s2_r[4];
    wire [3:0] din_now  = pin_s2_r[3:0];
    wire [1:0] fmt      = iface_r[`FMT_HI:`FMT_LO];
    wire       frame_clock_polarity      = iface_r[`LRP_BIT];
    wire       bit_clock_polarity      = iface_r[`BCP_BIT];
    wire [1:0] input_word_length      = iface_r[`IWL_HI:`IWL_LO];
    wire [2:0] phase    = iface_r[`PHASE_HI:`PHASE_LO];
    wire       inv4     = p4_r[`OUTPUT_INVERT_PAIR4_BIT];
    wire       gate_on  = ~dacctl_r[`DZC_BIT];
    wire       is_rj    = (fmt == `FMT_RJ);
    wire       is_i2s   = (fmt == `FMT_I2S);
    wire       is_dsp   = (fmt == `FMT_DSP);
    // Sampling edge follows the bit clock polarity bit
    wire samp_edge = bit_clock_polarity ? (bclk_s3_r & ~pin_s2_r[5]) : (~bclk_s3_r & pin_s2_r[5]);

    //************************************************************
    // Control registers
    //************************************************************
    ctrl_serial_port u_ctrl (
        .clk           (clk),
        .arst_n        (arst_n),
        .ce            (ce),
        .ctl_clk_pin   (control_clock_pin),
        .ctl_data_pin  (control_data_pin),
        .ctl_latch_pin (control_latch_pin),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_stb        (wr_stb)
    );

    // The serial port only exists in software mode, so writes need it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            iface_r  <= `RST_INTERFACE_CONTROL;
            dacctl_r <= `RST_DAC_CONTROL;
            p4_r     <= `RST_PAIR4_CONTROL;
        end else if (ce && wr_stb && sw_mode) begin
            case (wr_addr)
                `ADDR_INTERFACE_CONTROL: iface_r <= wr_data;
                `ADDR_DAC_CONTROL:       dacctl_r <= wr_data;
                `ADDR_PAIR4_CONTROL:     p4_r <= wr_data;
                default: ;
            endcase
        end
    end

    //************************************************************
    // Framing and word assembly
    //************************************************************
    wire lr_tog     = samp_edge && (lr_now != lr_prev_r);
    wire dsp_rise   = samp_edge && is_dsp && lr_now && !lr_prev_r;
    wire auto_mode  = is_i2s && (input_word_length == `IWL_24);
    wire auto16_now = auto_mode && (cnt_r == `AUTO16_HALF) && (prev_half_r == `AUTO16_HALF);
    wire dsp_word   = samp_edge && is_dsp && dsp_act_r && !dsp_rise && (cnt_r + 7'd1 == wl_bits);
    wire ev_norm    = lr_tog && !is_dsp && !auto16_now;
    // In a 32-clock I2S frame the LSB lands on the frame edge itself
    wire ev_late    = lr_tog && auto16_now;
    wire ch_lvl     = lr_prev_r;
    wire is_left    = ch_lvl ^ is_i2s ^ frame_clock_polarity;
    wire use_nx     = is_dsp || ev_late;
    wire [1:0] iwl_eff = ev_late ? `IWL_16 :
                         (is_rj && input_word_length == `IWL_32) ? `IWL_24 : input_word_length;
    // Right-aligned, DSP and late 16-bit words take the low bits, others count from frame edge
    wire [6:0] amt  = (is_rj || use_nx) ? SH_TOP - wl_bits
                                        : SH_TOP - cnt_r + {6'd0, is_i2s};
    wire frame_done = (dsp_word && slot_r == 3'd7) ||
                      ((ev_norm || ev_late) && !is_left);

    always @* begin
        case (iwl_eff)
            `IWL_16: wl_bits = 7'd16;
            `IWL_20: wl_bits = 7'd20;
            `IWL_24: wl_bits = 7'd24;
            default: wl_bits = 7'd32;
        endcase
    end

    // MSB-align, keep the top 24 bits, clear bits past the word
    function [23:0] extract;
        input [SHW-1:0] src;
        input [6:0]     sh;
        input [1:0]     wlc;
        reg   [SHW-1:0] al;
        begin
            al = src << sh;
            extract = al[SHW-1 -: 24] & ((wlc == `IWL_16) ? 24'hffff00 :
                      (wlc == `IWL_20) ? 24'hfffff0 : 24'hffffff);
        end
    endfunction

    // One shift register per data line
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_line
            reg  [SHW-1:0] sh_r;
            wire [SHW-1:0] sh_nx = {sh_r[SHW-2:0], din_now[g]};
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    sh_r <= {SHW{1'b0}};
                end else if (ce && samp_edge) begin
                    sh_r <= sh_nx;
                end
            end
            assign line_word[g*24 +: 24] = extract(use_nx ? sh_nx : sh_r, amt, iwl_eff);
        end
    endgenerate

    // Bit counting per half frame, or per word in DSP framing
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lr_prev_r     <= 1'b0;
            cnt_r         <= 7'd0;
            prev_half_r   <= 7'd0;
            auto16_active <= 1'b0;
            dsp_act_r     <= 1'b0;
            slot_r        <= 3'd0;
        end else if (ce && samp_edge) begin
            lr_prev_r <= lr_now;
            if (is_dsp) begin
                if (dsp_rise) begin
                    cnt_r     <= frame_clock_polarity ? 7'd1 : 7'd0;
                    slot_r    <= 3'd0;
                    dsp_act_r <= 1'b1;
                end else if (dsp_word) begin
                    cnt_r  <= 7'd0;
                    slot_r <= slot_r + 3'd1;
                    if (slot_r == 3'd7) begin
                        dsp_act_r <= 1'b0;
                    end
                end else if (dsp_act_r) begin
                    cnt_r <= cnt_r + 7'd1;
                end
            end else begin
                dsp_act_r <= 1'b0;
                if (lr_tog) begin
                    cnt_r         <= 7'd1;
                    prev_half_r   <= cnt_r;
                    auto16_active <= auto16_now;
                end else if (cnt_r != SH_TOP) begin
                    cnt_r <= cnt_r + 7'd1;
                end
            end
        end
    end

    //************************************************************
    // Word staging into the sample store
    //************************************************************
    // Lowest pending line is written first
    always @* begin
        wsel = 2'd0;
        for (m = 3; m >= 0; m = m - 1) begin
            if (pend_r[m]) begin
                wsel = m[1:0];
            end
        end
    end

    wire proc_start = (st_r == P_IDLE) && proc_req_r && !(|pend_r);

    // A new word sets pending after the drain clear, so it is never lost
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_r     <= 4'h0;
            proc_req_r <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                hold_w_r[k] <= 24'h000000;
                hold_a_r[k] <= 3'd0;
            end
        end else if (ce) begin
            if (|pend_r) begin
                pend_r[wsel] <= 1'b0;
            end
            if (proc_start) begin
                proc_req_r <= 1'b0;
            end
            if (dsp_word) begin
                hold_w_r[0] <= line_word[23:0];
                hold_a_r[0] <= slot_r;
                pend_r[0]   <= 1'b1;
            end else if (ev_norm || ev_late) begin
                for (k = 0; k < 4; k = k + 1) begin
                    hold_w_r[k] <= line_word[k*24 +: 24];
                    hold_a_r[k] <= {k[1:0], ~is_left};
                end
                pend_r <= 4'hf;
            end
            if (frame_done) begin
                proc_req_r <= 1'b1;
            end
        end
    end

    sample_store #(
        .DW (24),
        .AW (3)
    ) u_store (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .wr_en   (|pend_r),
        .wr_addr (hold_a_r[wsel]),
        .wr_data (hold_w_r[wsel]),
        .rd_addr (idx_r),
        .rd_data (rd_data)
    );

    //************************************************************
    // Per-channel phase, volume and soft mute
    //************************************************************
    wire [1:0]  pair    = idx_r[2:1];
    wire        inv     = (pair == 2'd3) ? inv4 : phase[pair];
    wire [23:0] s_neg   = (rd_data == 24'h800000) ? 24'h7fffff : (~rd_data + 24'h000001);
    wire [23:0] s_ph    = inv ? s_neg : rd_data;
    wire        zc_hit  = (s_ph[23] != sign_r[idx_r]) || (s_ph == 24'h000000);
    wire        vol_upd = vpend_r[idx_r] && zc_hit;
    wire [7:0]  vol_use = vol_upd ? vpv_r[idx_r] : vol_r[idx_r];
    wire [9:0]  gain    = {2'b00, vol_use} + 10'd1;
    wire signed [33:0] prod = $signed(s_ph) * $signed(gain);
    wire [23:0] scaled  = prod[31:8];
    wire [23:0] lvl     = lvl_r[idx_r];
    // Decay stalls within 63 codes above zero, negative levels reach zero; below the converter's noise
    wire [23:0] decayed = $signed(lvl) - ($signed(lvl) >>> `DECAY_SHIFT);
    wire        mute_on = soft_mute_req[pair] & sw_mode;
    wire [23:0] s_out   = mute_on ? decayed : scaled;

    // Eight channels one after another, each read then computed
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r        <= P_IDLE;
            idx_r       <= 3'd0;
            dac_sample  <= 24'h000000;
            dac_channel <= 3'd0;
            dac_valid   <= 1'b0;
            sign_r      <= 8'h00;
            vpend_r     <= 8'h00;
            for (j = 0; j < 8; j = j + 1) begin
                vol_r[j] <= `VOL_RESET;
                vpv_r[j] <= `VOL_RESET;
                lvl_r[j] <= 24'h000000;
            end
        end else if (ce) begin
            dac_valid <= 1'b0;
            case (st_r)
                P_IDLE: begin
                    if (proc_start) begin
                        idx_r <= 3'd0;
                        st_r  <= P_READ;
                    end
                end
                P_READ: st_r <= P_CALC;
                P_CALC: begin
                    dac_sample    <= s_out;
                    dac_channel   <= idx_r;
                    dac_valid     <= 1'b1;
                    sign_r[idx_r] <= s_ph[23];
                    lvl_r[idx_r]  <= s_out;
                    if (vol_upd) begin
                        vol_r[idx_r]   <= vpv_r[idx_r];
                        vpend_r[idx_r] <= 1'b0;
                    end
                    idx_r <= idx_r + 3'd1;
                    st_r  <= (idx_r == 3'd7) ? P_IDLE : P_READ;
                end
                default: st_r <= P_IDLE;
            endcase
            // A fresh load overrides an apply in the same cycle
            if (vol_load) begin
                if (gate_on) begin
                    vpv_r[vol_chan]   <= vol_value;
                    vpend_r[vol_chan] <= 1'b1;
                end else begin
                    vol_r[vol_chan]   <= vol_value;
                    vpend_r[vol_chan] <= 1'b0;
                end
            end
        end
    end

    // Analogue clamp per pair
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_mute <= 4'h0;
        end else if (ce) begin
            analog_mute <= {4{sw_mode & zero_detect_analog_mute}} & soft_mute_req;
        end
    end
endmodule // dac_audio_input_format_control
`default_nettype wire

// ---- tb/audio_in_checker.sv ----
// Checker for output cadence and analogue mute gating.
// Assumes bind onto the top module, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module audio_in_checker (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       control_mode_pin,
    input wire logic       zero_detect_analog_mute,
    input wire logic [3:0] soft_mute_req,
    input wire logic [2:0] dac_channel,
    input wire logic       dac_valid,
    input wire logic [3:0] analog_mute
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Burst: single pulses every second cycle, channels 0 to 7, then quiet
    a_valid_one_cycle: assert property (dac_valid |=> !dac_valid) else $error("valid held");
    a_channel_steps_up: assert property (dac_valid && dac_channel != 3'd7 |-> ##2 dac_valid &&
        dac_channel == $past(dac_channel, 2) + 3'd1) else $error("channel step");
    a_burst_from_zero: assert property (dac_valid && !$past(dac_valid, 2) |-> dac_channel == 3'd0)
        else $error("burst start");
    a_burst_gap_after: assert property (dac_valid && dac_channel == 3'd7 |=> !dac_valid [*3])
        else $error("burst end");
    a_reset_quiet_out: assert property ($rose(arst_n) |-> !dac_valid && analog_mute == 4'h0)
        else $error("reset outputs");
    // Mute gating; the mode pin passes a two-stage synchroniser first
    a_mute_hw_blocks: assert property (control_mode_pin [*4] |-> analog_mute == 4'h0) else $error("hw mute");
    a_mute_needs_enable: assert property (!zero_detect_analog_mute [*2] |-> analog_mute == 4'h0)
        else $error("mute enable");
    a_mute_follows_req: assert property ((!control_mode_pin && zero_detect_analog_mute) [*4] |=>
        analog_mute == $past(soft_mute_req)) else $error("mute request");
    c_full_burst: cover property (dac_valid && dac_channel == 3'd7);
    c_mute_on: cover property (analog_mute != 4'h0);
    c_hw_mode: cover property (control_mode_pin [*4]);
endmodule // audio_in_checker
bind dac_audio_input_format_control audio_in_checker i_chk (.clk, .arst_n, .control_mode_pin,
    .zero_detect_analog_mute, .soft_mute_req, .dac_channel, .dac_valid, .analog_mute);
`default_nettype wire

// ---- tb/audio_source_model.sv ----
// Audio source model: bit clock, frame clock and four data lines.
// Assumes the bench loads w and calls send; bit clock stands still between frames.
`timescale 1ns/1ns
`default_nettype none
module audio_source_model (
    output var logic       bit_clock,
    output var logic       frame_clock,
    output var logic [3:0] serial_data_inputs
);
    logic [31:0] w [8];
    logic        bit_clock_polarity = 1'b0;
    initial begin
        bit_clock = 1'b0;
        frame_clock = 1'b0;
        serial_data_inputs = 4'h0;
    end
    // Idle level follows the sampling edge, so idling adds no sampling edge
    task automatic set_bcp(input logic b);
        bit_clock_polarity = b;
        bit_clock = b;
    endtask
    // One frame at 48 ns a bit; unused slots toggle so stale bits never look valid
    // Two-half frames repeat: the closing step is also the next frame's first step
    task automatic send(input int n, input int d, input logic lvl, input logic dsp);
        int k;
        int i;
        for (int t = !dsp && frame_clock == lvl; t <= (dsp ? 8 * n + d : 2 * n); t++) begin
            k = dsp ? (t - d) / n : (t + 2 * n - d) % (2 * n) / n;
            i = (t + 2 * n - d) % n;
            frame_clock = dsp ? (t == 0) : ((t / n) % 2 == 0 ? lvl : !lvl);
            for (int l = 0; l < 4; l++) begin
                if ((t >= d || !dsp) && k < (dsp ? 8 : 2) && (!dsp || l == 0))
                    serial_data_inputs[l] = w[dsp ? k : 2 * l + k][31 - i];
                else
                    serial_data_inputs[l] = !serial_data_inputs[l];
            end
            #12 bit_clock = !bit_clock_polarity;
            #24 bit_clock = bit_clock_polarity;
            #12;
        end
        serial_data_inputs = ~serial_data_inputs;
    endtask
endmodule // audio_source_model
`default_nettype wire

// ---- tb/dac_audio_input_format_control_tb_top.sv ----
// Bench: framings, word lengths, inversion and analogue mute of the audio input stage.
// Assumes the source model and the bound checker; clk at 250 MHz.
`timescale 1ns/1ns
`default_nettype none
module dac_audio_input_format_control_tb_top;
    logic        clk = 1'b0, arst_n = 1'b0, control_mode_pin = 1'b0, zero_detect_analog_mute = 1'b0;
    logic        control_clock_pin = 1'b0, control_data_pin = 1'b0, control_latch_pin = 1'b0;
    logic [3:0]  soft_mute_req = 4'h0;
    logic [31:0] words [8];
    logic [23:0] cap [8];
    int          n_burst = 0, n_mismatch = 0, check_count = 0;
    wire         bit_clock, frame_clock, dac_valid, auto16_active;
    wire  [3:0]  serial_data_inputs, analog_mute;
    wire  [23:0] dac_sample;
    wire  [2:0]  dac_channel;
    dac_audio_input_format_control i_dac_audio_input_format_control (.clk, .arst_n, .ce(1'b1), .bit_clock,
        .frame_clock, .serial_data_inputs, .control_clock_pin, .control_data_pin, .control_latch_pin,
        .control_mode_pin, .zero_detect_analog_mute, .soft_mute_req, .vol_value(8'hff), .vol_chan(3'h0),
        .vol_load(1'b0), .dac_sample, .dac_channel, .dac_valid, .analog_mute, .auto16_active);
    audio_source_model i_audio_source_model (.bit_clock, .frame_clock, .serial_data_inputs);
    initial forever #2 clk = ~clk;
    // Latest word of each channel; a channel 7 pulse closes a burst
    always @(posedge clk) if (dac_valid === 1'b1) begin
        cap[dac_channel] <= dac_sample;
        n_burst <= n_burst + (dac_channel == 3'd7);
    end
    task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // Control word, MSB first; each pin level held four cycles for the synchroniser
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        logic [15:0] b = {a, d};
        for (int i = 47; i >= 0; i--) begin
            {control_clock_pin, control_data_pin} <= {i % 3 == 1, b[i / 3]};
            repeat (4) @(posedge clk);
        end
        control_latch_pin <= 1'b1;
        repeat (8) @(posedge clk);
        control_latch_pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // First frame flushes the old framing, the second one is judged
    task automatic run(input logic [8:0] r, input int n, input int d, input logic lvl);
        int          b0;
        logic [23:0] e;
        logic [23:0] m;
        wr(7'h03, r);
        i_audio_source_model.set_bcp(r[3]);
        i_audio_source_model.send(n, d, lvl, r[1:0] == 2'b11);
        #200;
        b0 = n_burst;
        i_audio_source_model.send(n, d, lvl, r[1:0] == 2'b11);
        for (int i = 0; i < 200 && n_burst == b0; i++) @(posedge clk);
        if (n_burst == b0) begin
            n_mismatch++;
            end_sim();
        end
        m = (r[5:4] == 2'b00 || n == 16) ? 24'hffff00 : (r[5:4] == 2'b01 ? 24'hfffff0 : 24'hffffff);
        for (int c = 0; c < 8; c++) begin
            e = words[c][31:8] & m;
            if (c > 5 || r[6 + c / 2])
                e = (e == 24'h800000) ? 24'h7fffff : -e;
            chk("dac_sample", e, cap[c]);
        end
        if (n == 16 && r[1:0] == 2'b10)
            chk("auto16_active", 24'h1, {23'h0, auto16_active});
    endtask
    // Analogue mute follows requests with its enable set, and clears when leaving software mode
    task automatic mute_gating();
        zero_detect_analog_mute <= 1'b1;
        soft_mute_req <= 4'h5;
        repeat (8) @(posedge clk);
        chk("analog_mute", 24'h5, {20'h0, analog_mute});
        control_mode_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("analog_mute", 24'h0, {20'h0, analog_mute});
    endtask
    task automatic end_sim();
        $display("mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        words = '{32'h800000ff, 32'h7f123456, 32'hc0a55a3c, 32'h13579bdf, 32'hfedcba98, 32'h02468ace,
                  32'h80000000, 32'h5a5aa5a5};
        foreach (words[c]) i_audio_source_model.w[c] = words[c];
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wr(7'h0f, 9'h008);
        run(9'h000, 16, 0, 1'b1);
        run(9'h011, 24, 0, 1'b1);
        run(9'h0e1, 24, 0, 1'b1);
        run(9'h031, 32, 0, 1'b1);
        run(9'h030, 24, 0, 1'b1);
        run(9'h022, 32, 1, 1'b0);
        run(9'h026, 32, 1, 1'b1);
        run(9'h022, 16, 1, 1'b0);
        run(9'h027, 24, 0, 1'b0);
        run(9'h023, 24, 1, 1'b0);
        run(9'h029, 24, 0, 1'b1);
        mute_gating();
        end_sim();
    end
endmodule // dac_audio_input_format_control_tb_top
`default_nettype wire
